// ===== hw/prsc_pkg.sv
package prsc_pkg;

	// =========================================================
	// Register map (byte addresses of aligned words; the bases start blocks of several words)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS_CLR = 8'h08;
	localparam logic [7:0] ADDR_SCAN_LEN = 8'h0c;
	localparam logic [7:0] ADDR_CONTACT_SEL = 8'h10;
	localparam logic [7:0] ADDR_STEP = 8'h14;
	localparam logic [7:0] ADDR_CLOCK_BASE = 8'h20;
	localparam logic [7:0] ADDR_COMMON_BASE = 8'h40;
	localparam logic [7:0] ADDR_INDIV_BASE = 8'h80;
	localparam logic [7:0] ADDR_DATA_BASE = 8'hc0;

	// =========================================================
	// Sizes
	localparam int WORD_W = 16;
	localparam int ERR_WORDS = 11;
	localparam int CLK_WORDS = 4;
	localparam int DATA_WORDS = 16;
	localparam int CONTACT_NUM = 32;

	// =========================================================
	// Control register fields
	localparam int CTRL_TOOL_STOP = 0;
	localparam int CTRL_COMMON_REQ = 1;
	localparam int CTRL_INDIV_REQ = 2;
	localparam int CTRL_CLOCK_REQ = 3;
	localparam int CTRL_CONTACT_EN = 4;

	// Status register fields
	localparam int ST_RUN = 0;
	localparam int ST_DIAG = 1;
	localparam int ST_SELF = 2;
	localparam int ST_OP = 3;
	localparam int ST_ONE = 4;
	localparam int ST_ZERO = 5;
	localparam int ST_FIRST = 6;
	localparam int ST_FIRST_N = 7;
	localparam int ST_REMOTE_STOP = 8;

	// =========================================================
	// Reset values
	localparam logic [15:0] SCAN_LEN_RST = 16'h0010;
	localparam logic [4:0] CONTACT_SEL_RST = 5'h00;

	typedef enum logic [1:0] {
		PRSC_STOPPED,
		PRSC_SCANNING,
		PRSC_FINISH
	} prsc_state_t;

	typedef struct packed {
		logic diag;
		logic self_diag;
		logic op;
	} prsc_err_t;

endpackage

// ===== hw/prsc_top.sv
// Behaviour
// - Data words are 16 bits, accessed as whole words.
// - Words hold any pattern 0000 to ffff, signed -32768 to 32767.
// - A written data word keeps its value until rewritten.
// - Diagnostic error flag is sticky once any diagnostic error seen.
// - Self-diagnosis error flag is sticky once self-diagnosis fails.
// - Operation error flag is sticky once an instruction errors.
// - Common error words captured while common capture request is on.
// - Individual error words captured while individual capture request is on.
// - Clock words copied as BCD only while clock read request is on.
// - Constant-one flag always on, constant-zero always off.
// - First scan after run: pulse high one scan, inverted low one scan.
// - Basic run or stop follows the enable input level.
// - Remote run and stop act only while enable is on.
// - Remote stop lets the current scan reach its end first.
// - Remote run after remote stop restarts at step 0.
// - Remote contact off requests run, on requests stop.
// - Remote contact is selectable among inputs 0 to 31.
// - Stop from any source forces the stop state.
// - Run resumes only when every stop source requests run again.
// - In run, steps repeat from 0 to end, scan after scan.
// - In stop, program halts and all outputs are off.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module prsc_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Pins
	input wire logic i_plc_enable_input,
	input wire logic [31:0] i_inputs,
	// Event sources from the program engine
	input wire logic i_diag_err,
	input wire logic i_self_diag_err,
	input wire logic i_op_err,
	input wire logic [15:0] i_err_code,
	input wire logic [15:0] i_clock_bcd,
	input wire logic [31:0] i_prog_outputs,
	// Status outputs
	output logic o_run,
	output logic [15:0] o_step,
	output logic o_scan_end,
	output logic o_first_scan_pulse,
	output logic o_first_scan_low_pulse,
	output logic o_constant_one_flag,
	output logic o_constant_zero_flag,
	output logic [31:0] o_outputs
);

	// =========================================================
	// Reset release through two flops
	// Assertion stays asynchronous so the block is quiet even without a clock,
	// while release is lined up with the clock so no flop sees a half-released
	// reset and the scan sequencer cannot leave its stopped state on a glitch.
	logic rst_s1_r, rst_n;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// =========================================================
	// Pin synchronisers: three flops, change accepted when last two agree
	// Bit 32 is the enable pin, bits 31 to 0 are the input contacts.
	// The agreement test filters a one-cycle bounce on a contact, at the cost
	// of about four cycles of latency between a pin change and its effect.
	// Only the second flop reads the first, so metastability stays contained.
	logic [32:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_r <= '0;
		end else begin
			pin_s1_r <= {i_plc_enable_input, i_inputs};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			for (int k = 0; k < 33; k++) begin
				if (pin_s2_r[k] == pin_s3_r[k]) pin_r[k] <= pin_s3_r[k];
			end
		end
	end
	wire logic enable_lvl = pin_r[32];

	// =========================================================
	// Registers written by software
	// The tool stop bit stands for the engineering tool's request; it stays
	// until software writes it again, so a lost tool session keeps the
	// controller stopped rather than letting it run unattended.
	logic tool_stop_r, common_req_r, indiv_req_r, clock_req_r, contact_en_r;
	logic [15:0] scan_len_r;
	logic [4:0] contact_sel_r;
	logic [15:0] data_mem [prsc_pkg::DATA_WORDS];
	logic [15:0] common_mem [prsc_pkg::ERR_WORDS];
	logic [15:0] indiv_mem [prsc_pkg::ERR_WORDS];
	logic [15:0] clock_mem [prsc_pkg::CLK_WORDS];

	wire logic wr_en = i_psel && i_penable && i_pwrite;
	wire logic rd_en = i_psel && i_penable && !i_pwrite;

	// Word index inside a block starting at base
	function automatic logic [5:0] word_idx(input logic [7:0] addr, input logic [7:0] base);
		word_idx = 6'((addr - base) >> 2);
	endfunction

	// Address inside the half-open window [lo, hi)
	function automatic logic in_range(input logic [7:0] addr, input logic [7:0] lo, input logic [7:0] hi);
		in_range = (addr >= lo) && (addr < hi);
	endfunction

	// Last step of a scan; a length of zero wraps to ffff, so a scan runs 65536 steps
	function automatic logic last_step(input logic [15:0] step, input logic [15:0] len);
		last_step = step >= len - 16'h0001;
	endfunction

	// Control fields and scan configuration
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			tool_stop_r <= 1'b0;
			common_req_r <= 1'b0;
			indiv_req_r <= 1'b0;
			clock_req_r <= 1'b0;
			contact_en_r <= 1'b0;
			scan_len_r <= prsc_pkg::SCAN_LEN_RST;
			contact_sel_r <= prsc_pkg::CONTACT_SEL_RST;
		end else if (wr_en) begin
			if (i_paddr == prsc_pkg::ADDR_CTRL) begin
				tool_stop_r <= i_pwdata[prsc_pkg::CTRL_TOOL_STOP];
				common_req_r <= i_pwdata[prsc_pkg::CTRL_COMMON_REQ];
				indiv_req_r <= i_pwdata[prsc_pkg::CTRL_INDIV_REQ];
				clock_req_r <= i_pwdata[prsc_pkg::CTRL_CLOCK_REQ];
				contact_en_r <= i_pwdata[prsc_pkg::CTRL_CONTACT_EN];
			end
			if (i_paddr == prsc_pkg::ADDR_SCAN_LEN) scan_len_r <= i_pwdata[15:0];
			if (i_paddr == prsc_pkg::ADDR_CONTACT_SEL) contact_sel_r <= i_pwdata[4:0];
		end
	end

	// General data words: whole 16-bit writes, held until rewritten
	always_ff @(posedge i_clock) begin
		if (wr_en && i_paddr >= prsc_pkg::ADDR_DATA_BASE) begin
			data_mem[4'(word_idx(i_paddr, prsc_pkg::ADDR_DATA_BASE))] <= i_pwdata[15:0];
		end
	end

	// =========================================================
	// Run/stop arbitration
	// Stop wins over run: either source alone holds the block stopped, and
	// a run needs both the contact and the tool to ask for it again.
	// The contact only counts once software has enabled it, so a floating
	// input after power-up cannot stop the controller by accident.
	logic contact_stop;
	logic stop_req;
	assign contact_stop = contact_en_r && pin_r[contact_sel_r];
	assign stop_req = contact_stop || tool_stop_r;

	prsc_pkg::prsc_state_t state_r;
	logic [15:0] step_r;
	logic first_scan_r, remote_stop_r;

	// Scan sequencer
	// One step per clock; the scan runs from step 0 to the scan length less one.
	// A remote stop moves to the finishing state, which lets the scan run on
	// to its last step before stopping, so the program never halts mid-scan.
	// Dropping the enable pin stops at once, without finishing the scan.
	// The first-scan flag is raised on entry to run and dropped at the end of
	// that first scan, or at once if the enable pin falls during it.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= prsc_pkg::PRSC_STOPPED;
			step_r <= '0;
			first_scan_r <= 1'b0;
			remote_stop_r <= 1'b0;
		end else begin
			case (state_r)
				prsc_pkg::PRSC_STOPPED: begin
					step_r <= '0;
					if (enable_lvl && !stop_req) begin
						state_r <= prsc_pkg::PRSC_SCANNING;
						first_scan_r <= 1'b1;
						remote_stop_r <= 1'b0;
					end
				end
				prsc_pkg::PRSC_SCANNING, prsc_pkg::PRSC_FINISH: begin
					if (!enable_lvl) begin
						state_r <= prsc_pkg::PRSC_STOPPED;
						first_scan_r <= 1'b0;
					end else begin
						if (stop_req) state_r <= prsc_pkg::PRSC_FINISH;
						if (last_step(step_r, scan_len_r)) begin
							step_r <= '0;
							first_scan_r <= 1'b0;
							if (stop_req || state_r == prsc_pkg::PRSC_FINISH) begin
								state_r <= prsc_pkg::PRSC_STOPPED;
								remote_stop_r <= 1'b1;
							end
						end else begin
							step_r <= step_r + 16'h0001;
						end
					end
				end
				default: state_r <= prsc_pkg::PRSC_STOPPED;
			endcase
		end
	end

	wire logic running = state_r != prsc_pkg::PRSC_STOPPED;

	// =========================================================
	// Sticky error flags; set wins, clear by writing ones
	// A new event in the same cycle as a clear keeps the flag set, so an error
	// that arrives while software acknowledges an older one is never lost.
	// Operation errors count only while the program runs.
	prsc_pkg::prsc_err_t err_r;
	wire logic clr = wr_en && (i_paddr == prsc_pkg::ADDR_FLAGS_CLR);
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			err_r <= '0;
		end else begin
			err_r.diag <= i_diag_err || (err_r.diag && !(clr && i_pwdata[prsc_pkg::ST_DIAG]));
			err_r.self_diag <= i_self_diag_err || (err_r.self_diag && !(clr && i_pwdata[prsc_pkg::ST_SELF]));
			err_r.op <= (i_op_err && running) || (err_r.op && !(clr && i_pwdata[prsc_pkg::ST_OP]));
		end
	end

	// =========================================================
	// Capture blocks: error info and clock words while requested
	// Each block refreshes on every clock while its request bit is on and
	// freezes when the bit drops, so software reads a stable snapshot.
	// The words have no reset; read them only after a capture has run.
	always_ff @(posedge i_clock) begin
		for (int k = 0; k < prsc_pkg::ERR_WORDS; k++) begin
			if (common_req_r) common_mem[k] <= (k == 0) ? i_err_code : {15'h0000, err_r[k % 3]};
			if (indiv_req_r) indiv_mem[k] <= (k == 0) ? i_err_code : step_r;
		end
		for (int k = 0; k < prsc_pkg::CLK_WORDS; k++) begin
			if (clock_req_r) clock_mem[k] <= i_clock_bcd;
		end
	end

	// =========================================================
	// Outputs from flops
	// Every output lags the internal state by one clock, which keeps the
	// pins free of decode glitches; all status outputs share that lag.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_run <= 1'b0;
			o_step <= '0;
			o_scan_end <= 1'b0;
		end else begin
			o_run <= running;
			o_step <= step_r;
			o_scan_end <= running && last_step(step_r, scan_len_r);
		end
	end

	// Timing flags; the low-active first-scan flag idles high through reset
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_first_scan_pulse <= 1'b0;
			o_first_scan_low_pulse <= 1'b1;
			o_constant_one_flag <= 1'b1;
			o_constant_zero_flag <= 1'b0;
		end else begin
			o_first_scan_pulse <= first_scan_r;
			o_first_scan_low_pulse <= !first_scan_r;
			o_constant_one_flag <= 1'b1;
			o_constant_zero_flag <= 1'b0;
		end
	end

	// Program outputs, forced off whenever the program is stopped
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_outputs <= '0;
		end else begin
			o_outputs <= running ? i_prog_outputs : 32'h0000_0000;
		end
	end

	// =========================================================
	// APB read path; answers in the access cycle, no wait states
	// Decoded from the setup-cycle address and registered, so read data
	// stands on the bus for the whole access cycle.
	// Unaligned and unmapped addresses answer with an error and zero data.
	logic [31:0] rdata;
	logic bad;
	always_comb begin
		logic [5:0] idx;
		idx = 6'h00;
		rdata = 32'h0000_0000;
		bad = 1'b0;
		if (i_paddr[1:0] != 2'b00) begin
			bad = 1'b1;
		end else if (i_paddr == prsc_pkg::ADDR_CTRL) begin
			rdata = {27'h0, contact_en_r, clock_req_r, indiv_req_r, common_req_r, tool_stop_r};
		end else if (i_paddr == prsc_pkg::ADDR_STATUS || i_paddr == prsc_pkg::ADDR_FLAGS_CLR) begin
			rdata[prsc_pkg::ST_RUN] = running;
			rdata[prsc_pkg::ST_DIAG] = err_r.diag;
			rdata[prsc_pkg::ST_SELF] = err_r.self_diag;
			rdata[prsc_pkg::ST_OP] = err_r.op;
			rdata[prsc_pkg::ST_ONE] = 1'b1;
			rdata[prsc_pkg::ST_ZERO] = 1'b0;
			rdata[prsc_pkg::ST_FIRST] = first_scan_r;
			rdata[prsc_pkg::ST_FIRST_N] = !first_scan_r;
			rdata[prsc_pkg::ST_REMOTE_STOP] = remote_stop_r;
		end else if (i_paddr == prsc_pkg::ADDR_SCAN_LEN) begin
			rdata = {16'h0, scan_len_r};
		end else if (i_paddr == prsc_pkg::ADDR_CONTACT_SEL) begin
			rdata = {27'h0, contact_sel_r};
		end else if (i_paddr == prsc_pkg::ADDR_STEP) begin
			rdata = {16'h0, step_r};
		end else if (in_range(i_paddr, prsc_pkg::ADDR_CLOCK_BASE, 8'h30)) begin
			idx = word_idx(i_paddr, prsc_pkg::ADDR_CLOCK_BASE);
			rdata = {16'h0, clock_mem[2'(idx)]};
		end else if (in_range(i_paddr, prsc_pkg::ADDR_COMMON_BASE, 8'h6c)) begin
			idx = word_idx(i_paddr, prsc_pkg::ADDR_COMMON_BASE);
			rdata = {16'h0, common_mem[4'(idx)]};
		end else if (in_range(i_paddr, prsc_pkg::ADDR_INDIV_BASE, 8'hac)) begin
			idx = word_idx(i_paddr, prsc_pkg::ADDR_INDIV_BASE);
			rdata = {16'h0, indiv_mem[4'(idx)]};
		end else if (i_paddr >= prsc_pkg::ADDR_DATA_BASE) begin
			idx = word_idx(i_paddr, prsc_pkg::ADDR_DATA_BASE);
			rdata = {16'h0, data_mem[4'(idx)]};
		end else begin
			bad = 1'b1;
		end
	end

	// Registered answer; pready follows setup by one cycle
	// The slave never stretches a transfer: a master that holds penable past
	// the ready cycle gets no second ready until it starts a new setup.
	// Read data holds until the next read, error and ready are one-cycle pulses.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && bad;
			if (i_psel && !i_penable && !i_pwrite) o_prdata <= rdata;
		end
	end

endmodule // prsc_top

`default_nettype wire

// ===== testbench/prsc_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module prsc_chk (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Watched ports
	input wire logic i_pwrite,
	input wire logic i_plc_enable_input,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_run,
	input wire logic [15:0] o_step,
	input wire logic o_scan_end,
	input wire logic o_first_scan_pulse,
	input wire logic o_first_scan_low_pulse,
	input wire logic o_constant_one_flag,
	input wire logic o_constant_zero_flag,
	input wire logic [31:0] o_outputs
);
	// =========================================================
	// Properties, one clock domain
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	a_const_flags: assert property (o_constant_one_flag && !o_constant_zero_flag)
		else $error("constant flags wrong");
	a_first_inverse: assert property (o_first_scan_pulse != o_first_scan_low_pulse)
		else $error("first scan pair not inverse");
	a_first_in_run: assert property (o_first_scan_pulse |-> o_run)
		else $error("first scan pulse while stopped");
	a_first_one_scan: assert property (o_first_scan_pulse && o_scan_end |=> !o_first_scan_pulse)
		else $error("first scan pulse too long");
	a_run_step_zero: assert property ($rose(o_run) |-> o_step == 16'h0000)
		else $error("run did not start at step zero");
	a_step_advance: assert property (o_run && !o_scan_end |=> !o_run || o_step == $past(o_step) + 16'h0001)
		else $error("step did not advance");
	a_step_wrap: assert property (o_run && o_scan_end |=> !o_run || o_step == 16'h0000)
		else $error("scan did not restart at zero");
	// Only a stop with the enable held high is a remote stop
	a_stop_end_scan: assert property ($fell(o_run) && $past(i_plc_enable_input, 6)
		&& $past(i_plc_enable_input) |-> $past(o_scan_end))
		else $error("remote stop before scan end");
	// Pin sync takes four edges, the stop one more, the output flop one more
	a_enable_stop: assert property (!i_plc_enable_input [*7] |-> !o_run)
		else $error("running with enable low");
	a_stop_out_off: assert property (!o_run && !$past(o_run) |-> o_outputs == 32'h0)
		else $error("outputs on while stopped");
	a_read_upper: assert property (o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
endmodule // prsc_chk

bind prsc_top prsc_chk i_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_pwrite(i_pwrite),
	.i_plc_enable_input(i_plc_enable_input), .o_prdata(o_prdata), .o_pready(o_pready), .o_run(o_run),
	.o_step(o_step), .o_scan_end(o_scan_end), .o_first_scan_pulse(o_first_scan_pulse),
	.o_first_scan_low_pulse(o_first_scan_low_pulse), .o_constant_one_flag(o_constant_one_flag),
	.o_constant_zero_flag(o_constant_zero_flag), .o_outputs(o_outputs));

`default_nettype wire

// ===== testbench/prsc_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module prsc_far_model (
	// Clock
	input wire logic i_clock,
	// Bench commands
	input wire logic i_run_pin,
	input wire logic i_contact_stop,
	input wire logic [4:0] i_contact_idx,
	// Pins towards the device
	output logic o_enable = 1'b0,
	output logic [31:0] o_inputs = 32'h0
);
	// =========================================================
	// Pins change after the edge, like real switches on a sync
	logic [31:0] noise_r = 32'h5555_5555;

	// Unselected contacts toggle so a wrong selection shows up
	always @(posedge i_clock) begin
		noise_r <= ~noise_r;
		o_enable <= i_run_pin;
		o_inputs <= (noise_r & ~(32'h1 << i_contact_idx)) | ({31'h0, i_contact_stop} << i_contact_idx);
	end
endmodule // prsc_far_model

`default_nettype wire

// ===== testbench/tb_plc_run_stop_status_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_plc_run_stop_status_control;
	// =========================================================
	// Signals
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x;} prsc_row_t;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, run_pin, contact, en_pin, er;
	logic diag, selfd, operr, run, scan_end, first, first_n, one, zero;
	logic [4:0] cidx;
	logic [7:0] paddr;
	logic [15:0] err_code, bcd, step;
	logic [31:0] pwdata, prdata, inputs, prog, outs, rd;
	int n_errors = 0;
	int tests_run = 0;
	prsc_row_t rows [4] = '{'{8'hc0, 32'h8000, 32'h8000}, '{8'hc4, 32'h7fff, 32'h7fff},
		'{8'hc8, 32'hffff_1234, 32'h1234}, '{8'hfc, 32'hffff, 32'hffff}};

	prsc_top i_dut (.i_clock(clock), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_plc_enable_input(en_pin), .i_inputs(inputs), .i_diag_err(diag),
		.i_self_diag_err(selfd), .i_op_err(operr), .i_err_code(err_code), .i_clock_bcd(bcd),
		.i_prog_outputs(prog), .o_run(run), .o_step(step), .o_scan_end(scan_end),
		.o_first_scan_pulse(first), .o_first_scan_low_pulse(first_n), .o_constant_one_flag(one),
		.o_constant_zero_flag(zero), .o_outputs(outs));
	prsc_far_model i_far (.i_clock(clock), .i_run_pin(run_pin), .i_contact_stop(contact),
		.i_contact_idx(cidx), .o_enable(en_pin), .o_inputs(inputs));

	// Clock, 40 ns period
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// One APB transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		`CHK(pready, 1'b1)
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wait_run(input logic v);
		for (int k = 0; k < 60; k++) begin
			@(posedge clock);
			if (run === v) break;
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#800000;
		n_errors++;
		tally_and_finish();
	end

	// =========================================================
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, run_pin, contact, diag, selfd, operr} = '0;
		{cidx, paddr, err_code, bcd, pwdata, prog} = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK({one, zero, first, first_n, run}, 5'b10010)
		apb(1'b0, prsc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h90)
		$display("test reset done");
		// Write all four words first so read-back shows retention
		for (int i = 0; i < 4; i++) apb(1'b1, rows[i].a, rows[i].d);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, rows[i].a, 32'h0);
			`CHK(rd, rows[i].x)
		end
		foreach (rows[i]) begin
			apb(1'b0, 8'h18 + 8'(i), 32'h0);
			`CHK({er, rd}, 33'h1_0000_0000)
		end
		$display("test data words done");
		apb(1'b1, prsc_pkg::ADDR_SCAN_LEN, 32'h4);
		run_pin <= 1'b1;
		wait_run(1'b1);
		`CHK({run, step, first, first_n}, 19'h40002)
		for (int k = 0; k < 10 && scan_end !== 1'b1; k++) @(posedge clock);
		`CHK(step, 16'h3)
		@(posedge clock);
		`CHK({step, first, first_n}, 18'h00001)
		prog <= 32'ha5a5_0f0f;
		{diag, selfd, operr} <= 3'b111;
		@(posedge clock);
		{diag, selfd, operr} <= 3'b000;
		repeat (3) @(posedge clock);
		`CHK(outs, 32'ha5a5_0f0f)
		apb(1'b0, prsc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h9f)
		apb(1'b1, prsc_pkg::ADDR_FLAGS_CLR, 32'he);
		apb(1'b0, prsc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h91)
		$display("test run and flags done");
		err_code <= 16'h1234;
		bcd <= 16'h0599;
		apb(1'b1, prsc_pkg::ADDR_CTRL, 32'he);
		apb(1'b1, prsc_pkg::ADDR_CTRL, 32'h0);
		err_code <= 16'h4321;
		bcd <= 16'h1200;
		apb(1'b0, prsc_pkg::ADDR_COMMON_BASE, 32'h0);
		`CHK(rd, 32'h1234)
		apb(1'b0, prsc_pkg::ADDR_INDIV_BASE, 32'h0);
		`CHK(rd, 32'h1234)
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, prsc_pkg::ADDR_CLOCK_BASE + 8'(4 * k), 32'h0);
			`CHK(rd, 32'h0599)
		end
		$display("test capture done");
		apb(1'b1, prsc_pkg::ADDR_CONTACT_SEL, 32'h1f);
		cidx <= 5'h1f;
		apb(1'b1, prsc_pkg::ADDR_CTRL, 32'h10);
		contact <= 1'b1;
		wait_run(1'b0);
		`CHK(run, 1'b0)
		apb(1'b1, prsc_pkg::ADDR_CTRL, 32'h11);
		contact <= 1'b0;
		apb(1'b0, prsc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h190)
		apb(1'b1, prsc_pkg::ADDR_CTRL, 32'h10);
		wait_run(1'b1);
		`CHK({run, step, first}, 18'h20001)
		$display("test remote done");
		run_pin <= 1'b0;
		wait_run(1'b0);
		repeat (2) @(posedge clock);
		`CHK(outs, 32'h0)
		diag <= 1'b1;
		@(posedge clock);
		diag <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		apb(1'b0, prsc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h90)
		$display("test stop and reset done");
		tally_and_finish();
	end
endmodule // tb_plc_run_stop_status_control

`default_nettype wire
